// ===== gain_pin_board.sv
// Board-side model of the gain pins.
// Assumes the device wins where it drives; the board drives on request.
`timescale 1ns/100ps
`default_nettype none

module gain_pin_board #(
  parameter int NUM_PINS = 4
) (
  input wire logic clk_i,
  input wire logic [NUM_PINS-1:0] dev_o_i,
  input wire logic [NUM_PINS-1:0] dev_oe_i,
  input wire logic [NUM_PINS-1:0] drive_i,
  input wire logic [NUM_PINS-1:0] drive_en_i,
  output logic [NUM_PINS-1:0] level_o
);
  logic [NUM_PINS-1:0] float_q = '0;

  // Undriven pins wander so a stale level never reads as valid
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // Wire level from both parties' enables
  always_comb begin
    level_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & drive_en_i & drive_i)
      | (~dev_oe_i & ~drive_en_i & float_q);
  end
endmodule : gain_pin_board
`default_nettype wire

// ===== gain_pin_gpio_override.sv
// Gain-pin general-purpose override with a Wishbone register slave.
// Assumes a classic Wishbone master on clk_i and pins that arrive
// asynchronously; normal-function drive comes from logic on clk_i.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module gain_pin_gpio_override #(
  parameter int NUM_PINS = gpio_override_pkg::PIN_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [gpio_override_pkg::ADR_WIDTH-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [gpio_override_pkg::DATA_WIDTH-1:0] dat_i,
  output logic [gpio_override_pkg::DATA_WIDTH-1:0] dat_o,
  output logic ack_o,
  // Normal-function drive of the pins from the gain logic
  input wire logic [NUM_PINS-1:0] func_out_i,
  input wire logic [NUM_PINS-1:0] func_oe_i,
  input wire logic peak_flag_a_i,
  // Gain pins, split into input, output and output enable
  input wire logic [NUM_PINS-1:0] gain_pin_i,
  output logic [NUM_PINS-1:0] gain_pin_o,
  output logic [NUM_PINS-1:0] gain_pin_oe_o
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (NUM_PINS < 3 || NUM_PINS > 8) begin : g_bad_width
    $error("NUM_PINS must lie between 3 and 8");
  end

  localparam int DW = gpio_override_pkg::DATA_WIDTH;

  typedef struct packed {
    logic [NUM_PINS-1:0] mask;
    logic [NUM_PINS-1:0] dir;
    logic [NUM_PINS-1:0] level;
    logic flag_en;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic ack;
    logic [DW-1:0] rdat;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic [NUM_PINS-1:0] in_sync;
  logic req;
  logic wr_commit;

  // ************************************************************
  // Helpers
  // ************************************************************

  // Word index match on the byte address
  function automatic logic hit(
    input logic [gpio_override_pkg::ADR_WIDTH-1:0] adr,
    input logic [9:0] idx
  );
    hit = (adr[gpio_override_pkg::ADR_WIDTH-1:2] == idx);
  endfunction : hit

  // Zero-extend a pin vector into a bus word
  function automatic logic [DW-1:0] widen(input logic [NUM_PINS-1:0] v);
    widen = '0;
    widen[NUM_PINS-1:0] = v;
  endfunction : widen

  // ************************************************************
  // Input synchronizer
  // ************************************************************

  // R8 pins synchronized
  pin_sync2 #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(gain_pin_i),
    .sync_o(in_sync)
  );

  // ************************************************************
  // Bus decode and next state
  // ************************************************************

  // Request is live and the write lands on the acknowledging edge
  assign req = cyc_i && stb_i;
  assign wr_commit = req && we_i && st_q.ack && sel_i[0];

  // Register writes, read mux and pin drive
  always_comb begin
    st_d = st_q;
    st_d.ack = req && !st_q.ack;
    st_d.rdat = '0;
    if (wr_commit) begin
      // R1 mask write
      if (hit(adr_i, gpio_override_pkg::IDX_MASK)) begin
        st_d.mask = dat_i[NUM_PINS-1:0];
      end
      // R2 direction write
      if (hit(adr_i, gpio_override_pkg::IDX_DIRECTION)) begin
        st_d.dir = dat_i[NUM_PINS-1:0];
      end
      // R3 level write
      if (hit(adr_i, gpio_override_pkg::IDX_OUT_LEVEL)) begin
        st_d.level = dat_i[NUM_PINS-1:0];
      end
      if (hit(adr_i, gpio_override_pkg::IDX_FLAG_ENABLE)) begin
        st_d.flag_en = dat_i[gpio_override_pkg::FLAG_EN_BIT];
      end
    end
    // Read data, unmapped addresses read zero
    if (req && !we_i && !st_q.ack) begin
      if (hit(adr_i, gpio_override_pkg::IDX_MASK)) begin
        st_d.rdat = widen(st_q.mask);
      end
      if (hit(adr_i, gpio_override_pkg::IDX_DIRECTION)) begin
        st_d.rdat = widen(st_q.dir);
      end
      if (hit(adr_i, gpio_override_pkg::IDX_OUT_LEVEL)) begin
        st_d.rdat = widen(st_q.level);
      end
      // R4 output readback
      if (hit(adr_i, gpio_override_pkg::IDX_OUT_READBACK)) begin
        st_d.rdat = widen(st_q.pin_out);
      end
      // R5 input readback
      if (hit(adr_i, gpio_override_pkg::IDX_IN_READBACK)) begin
        st_d.rdat = widen(in_sync);
      end
      if (hit(adr_i, gpio_override_pkg::IDX_FLAG_ENABLE)) begin
        st_d.rdat[gpio_override_pkg::FLAG_EN_BIT] = st_q.flag_en;
      end
    end
    // Per-pin drive selection
    for (int i = 0; i < NUM_PINS; i++) begin
      if (st_q.mask[i]) begin
        // R2 direction picks drive
        st_d.pin_oe[i] = st_q.dir[i];
        // R3 drive level
        st_d.pin_out[i] = st_q.dir[i] && st_q.level[i];
      end else if (i == gpio_override_pkg::FLAG_PIN) begin
        // R7 flag or low
        st_d.pin_oe[i] = 1'b1;
        st_d.pin_out[i] = st_q.flag_en && peak_flag_a_i;
      end else begin
        st_d.pin_oe[i] = func_oe_i[i];
        st_d.pin_out[i] = func_out_i[i];
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************

  // R6 reset clears overrides
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.mask <= gpio_override_pkg::RESET_VALUE[NUM_PINS-1:0];
      st_q.dir <= gpio_override_pkg::RESET_VALUE[NUM_PINS-1:0];
      st_q.level <= gpio_override_pkg::RESET_VALUE[NUM_PINS-1:0];
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign dat_o = st_q.rdat;
  assign ack_o = st_q.ack;
  assign gain_pin_o = st_q.pin_out;
  assign gain_pin_oe_o = st_q.pin_oe;

  // ************************************************************
  // Assertions
  // ************************************************************

  property p_mask_write;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wr_commit && hit(adr_i, gpio_override_pkg::IDX_MASK)
    |=> st_q.mask == $past(dat_i[NUM_PINS-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) // R1
    else $error("Mask write not stored");

  property p_input_released;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> (gain_pin_oe_o & $past(st_q.mask & ~st_q.dir)) == '0;
  endproperty
  a_input_released: assert property (p_input_released) // R2
    else $error("Overridden input pin is driven");

  property p_output_level;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> ((gain_pin_oe_o & $past(st_q.mask & st_q.dir))
              == $past(st_q.mask & st_q.dir))
          && ((gain_pin_o & $past(st_q.mask & st_q.dir))
              == $past(st_q.level & st_q.mask & st_q.dir));
  endproperty
  a_output_level: assert property (p_output_level) // R3
    else $error("Overridden output pin has wrong level");

  property p_out_readback;
    @(posedge clk_i) disable iff (rst_i)
    ack_o && $past(ce_i) && !we_i
      && hit(adr_i, gpio_override_pkg::IDX_OUT_READBACK)
    |-> dat_o[NUM_PINS-1:0] == $past(gain_pin_o);
  endproperty
  a_out_readback: assert property (p_out_readback) // R4
    else $error("Output readback differs from pins");

  property p_in_readback;
    @(posedge clk_i) disable iff (rst_i)
    ack_o && $past(ce_i) && !we_i
      && hit(adr_i, gpio_override_pkg::IDX_IN_READBACK)
    |-> dat_o[NUM_PINS-1:0] == $past(in_sync);
  endproperty
  a_in_readback: assert property (p_in_readback) // R5
    else $error("Input readback differs from synchronized pins");

  property p_reset_clear;
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> st_q.mask == '0 && st_q.dir == '0
      && st_q.level == '0 && !ack_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // R6
    else $error("Override registers not cleared by reset");

  property p_flag_pin;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !st_q.mask[gpio_override_pkg::FLAG_PIN]
    |=> gain_pin_oe_o[gpio_override_pkg::FLAG_PIN]
      && gain_pin_o[gpio_override_pkg::FLAG_PIN]
         == ($past(st_q.flag_en) && $past(peak_flag_a_i));
  endproperty
  a_flag_pin: assert property (p_flag_pin) // R7
    else $error("Pin 3 normal drive wrong");

  property p_sync_delay;
    @(posedge clk_i) disable iff (rst_i)
    $past(ce_i) && $past(ce_i, 2) && !$past(rst_i)
      && !$past(rst_i, 2)
    |-> in_sync == $past(gain_pin_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // R8
    else $error("Synchronizer delay is not two cycles");

  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ack_o |=> !ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("Acknowledge held longer than one cycle");

  c_output_mode: cover property (@(posedge clk_i) disable iff (rst_i)
    st_q.mask[0] && st_q.dir[0] && gain_pin_o[0]);
  c_input_read: cover property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !we_i && hit(adr_i, gpio_override_pkg::IDX_IN_READBACK));
  c_flag_out: cover property (@(posedge clk_i) disable iff (rst_i)
    !st_q.mask[gpio_override_pkg::FLAG_PIN]
    && gain_pin_o[gpio_override_pkg::FLAG_PIN]);

endmodule : gain_pin_gpio_override
`default_nettype wire

// ===== gain_pin_gpio_override_tb.sv
// Self-checking bench for the gain-pin override block.
// Assumes a Wishbone slave answering one cycle after a taken request.
`timescale 1ns/100ps
`default_nettype none

module gain_pin_gpio_override_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic peak = 0;
  logic ce = 1;
  logic [3:0] sel = 4'hf;
  logic ack_o;
  logic [11:0] adr = '0;
  logic [31:0] dat = '0, dat_o, rd, seed = 32'hbcef;
  logic [31:0] mask_m = '0, dir_m = '0, lvl_m = '0, flag_m = '0;
  logic [3:0] fout = '0, foe = '0, drv = '0, drv_en = 4'hf;
  logic [3:0] pins, po, poe;
  int miscompares = 0;
  int compares = 0;

  gain_pin_gpio_override DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .func_out_i(fout),
    .func_oe_i(foe), .peak_flag_a_i(peak), .gain_pin_i(pins),
    .gain_pin_o(po), .gain_pin_oe_o(poe));

  gain_pin_board board (.clk_i(clk_i), .dev_o_i(po), .dev_oe_i(poe),
    .drive_i(drv), .drive_en_i(drv_en), .level_o(pins));

  // ****************************************
  // Clock, random source and helpers
  // ****************************************
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic close_out();
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 50) begin
      miscompares++;
      close_out();
    end
  endtask : wb

  // Write a register and return its expected content
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] m);
    wb(1, a, d, rd);
    m = d & 32'h000f;
  endtask : wr

  // Pin drive and output readback against the model
  task automatic chk_pins();
    logic [31:0] eo, eoe, km;
    eo = '0;
    eoe = '0;
    km = '0;
    for (int i = 0; i < 4; i++) begin
      eoe[i] = mask_m[i] ? dir_m[i] : (i == 2) | foe[i];
      km[i] = mask_m[i] | (i == 2) | foe[i];
      eo[i] = mask_m[i] ? dir_m[i] & lvl_m[i]
        : (i == 2) ? flag_m[0] & peak : fout[i];
    end
    check("pin_oe", 32'(poe), eoe);
    check("pin_o", 32'(po) & km, eo & km);
    wb(0, 12'h6cc, '0, rd);
    check("out_readback", rd & km, eo & km);
  endtask : chk_pins

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (int k = 0; k < 2; k++) begin
      for (int a = 0; a < 5; a++) begin
        wb(0, 12'(12'h6c0 + 4 * a), '0, rd);
        check("reset_reg", rd, '0);
      end
      // Board lets go so undriven pins wander
      drv_en <= '0;
      chk_pins();
      repeat (10) begin
        seed = lfsr(seed);
        fout <= seed[15:12];
        foe <= seed[19:16];
        peak <= seed[20];
        wr(12'h6c0, seed, mask_m);
        wr(12'h6c4, seed >> 4, dir_m);
        wr(12'h6c8, seed >> 8, lvl_m);
        wr(12'h678, seed >> 21, flag_m);
        flag_m = flag_m & 32'h0001;
        wb(0, 12'h6c0, '0, rd);
        check("mask", rd, mask_m);
        wb(0, 12'h6c4, '0, rd);
        check("direction", rd, dir_m);
        wb(0, 12'h6c8, '0, rd);
        check("level", rd, lvl_m);
        chk_pins();
      end
      // Clock enable low freezes the pin drive
      ce <= 0;
      fout <= ~fout;
      foe <= ~foe;
      repeat (3) @(posedge clk_i);
      fout <= ~fout;
      foe <= ~foe;
      @(posedge clk_i);
      ce <= 1;
      chk_pins();
      wr(12'h6c0, 32'h000f, mask_m);
      // Write with byte lane 0 off is ignored
      sel <= 4'he;
      wb(1, 12'h6c0, 32'h0000, rd);
      sel <= 4'hf;
      wb(0, 12'h6c0, '0, rd);
      check("sel_ignored", rd, mask_m);
      wr(12'h6c4, 32'h0000, dir_m);
      drv_en <= 4'hf;
      repeat (4) begin
        seed = lfsr(seed);
        drv <= seed[3:0];
        repeat (4) @(posedge clk_i);
        wb(0, 12'h6d0, '0, rd);
        check("in_readback", rd, 32'(seed[3:0]));
      end
      chk_pins();
      wb(1, 12'h6cc, 32'h000f, rd);
      wb(1, 12'h7fc, 32'h000f, rd);
      wb(0, 12'h7fc, '0, rd);
      check("unmapped", rd, '0);
      chk_pins();
      @(posedge clk_i);
      rst_i <= 1;
      fout <= '0;
      foe <= '0;
      drv <= '0;
      drv_en <= 4'hf;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      mask_m = '0;
      dir_m = '0;
      lvl_m = '0;
      flag_m = '0;
    end
    close_out();
  end
endmodule : gain_pin_gpio_override_tb
`default_nettype wire

// ===== gpio_override_pkg.sv
// Constants shared by the gain-pin override block: register indices,
// field positions, reset values and bus widths.
// Assumes a classic Wishbone bus with 32-bit data and byte addressing.
//
// Overview of operation
// R1 - A 4-bit override mask hands gain pins 1 to 4 (bits 0 to 3) to general-purpose use, replacing their normal function.
// R2 - For an overridden pin a direction bit of 1 makes it an output and 0 an input; without the mask bit it has no effect.
// R3 - An overridden output pin is driven to the matching bit of the output level register.
// R4 - A read-only register returns the output bit states, equal to the pin levels for overridden outputs.
// R5 - A read-only register returns the input bit states, following the external pin levels.
// R6 - Reset clears the mask, direction and level bits so every pin keeps its normal function.
// R7 - When pin 3 is not overridden it drives low if its flag enable is 0, otherwise the selected peak flag.
// R8 - Each external pin level passes a two-stage synchronizer before it reaches the input readback register.
package gpio_override_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [9:0] IDX_FLAG_ENABLE = 10'h19e;
  localparam logic [9:0] IDX_MASK = 10'h1b0;
  localparam logic [9:0] IDX_DIRECTION = 10'h1b1;
  localparam logic [9:0] IDX_OUT_LEVEL = 10'h1b2;
  localparam logic [9:0] IDX_OUT_READBACK = 10'h1b3;
  localparam logic [9:0] IDX_IN_READBACK = 10'h1b4;

  // ************************************************************
  // Widths, field positions and reset values
  // ************************************************************
  localparam int PIN_COUNT = 4;
  localparam int ADR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam int FLAG_EN_BIT = 0;
  localparam int FLAG_PIN = 2;
  localparam logic [7:0] RESET_VALUE = 8'h00;

endpackage : gpio_override_pkg

// ===== pin_sync2.sv
// Two-flop synchronizer for a group of independent pin levels.
// Assumes each bit is a slow level; bits are not coherent as a word.
`timescale 1ns/100ps
`default_nettype none

module pin_sync2 #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // Refuse an empty pin group
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // ************************************************************
  // Stage logic
  // ************************************************************

  // R8 two flop chain
  always_comb begin
    st_d = st_q;
    st_d.first = async_i;
    st_d.second = st_q.first;
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.second;

endmodule : pin_sync2
`default_nettype wire
